// >>> inc/emoc_pkg.sv
// constants and carrier types for the event mask and overcurrent capture
// block; shared by the top module and its capture channel module
package emoc_pkg;

    // register word addresses on the internal register port
    localparam logic [15:0] ADDR_IRQ_MASK  = 16'h0406;
    localparam logic [15:0] ADDR_EVT_MASK  = 16'h0407;
    localparam logic [15:0] ADDR_OC_THRESH = 16'h0409;
    localparam logic [15:0] ADDR_OC_CAP_A  = 16'h040A;
    localparam logic [15:0] ADDR_OC_CAP_B  = 16'h040B;
    localparam logic [15:0] ADDR_OC_CAP_C  = 16'h040C;
    localparam logic [15:0] ADDR_OC_CAP_N  = 16'h040D;
    localparam logic [15:0] ADDR_FUND_LVL  = 16'h040F;

    // writable bits of each register; all other bits read zero
    localparam logic [31:0] IRQ_MASK_WR = 32'h000201FF;
    localparam logic [31:0] EVT_MASK_WR = 32'h0001FFFF;
    localparam logic [31:0] VAL24_WR    = 32'h00FFFFFF;

    // reset values
    localparam logic [31:0] IRQ_MASK_RST  = 32'h00000000;
    localparam logic [31:0] EVT_MASK_RST  = 32'h00000000;
    localparam logic [23:0] OC_THRESH_RST = 24'hFFFFFF;
    localparam logic [23:0] OC_CAP_RST    = 24'h000000;
    localparam logic [23:0] FUND_LVL_RST  = 24'h045D45;

    // interrupt mask field positions
    localparam int IRQ_OI_BIT     = 17;
    localparam int IRQ_ZXTO_LSB   = 6;
    localparam int IRQ_NOLOAD_LSB = 0;

    // event pin mask field positions
    localparam int EVT_WAVE_SAMPLE_READY_EN_BIT = 16;
    localparam int EVT_NOLOAD_LSB = 10;
    localparam int EVT_NEGDIR_LSB = 6;
    localparam int EVT_SWELL_LSB  = 3;
    localparam int EVT_DIP_LSB    = 0;

    // capture channel indices
    localparam int OC_CH_A = 0;
    localparam int OC_CH_N = 3;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } emoc_reg_req_t;

    // voltage quality states per phase, bit 0 is phase a
    typedef struct packed {
        logic [2:0] swell;
        logic [2:0] dip;
    } emoc_pq_t;

    // interrupt status conditions held by the metrology core
    typedef struct packed {
        logic       overcurrent;
        logic [2:0] zc_timeout;
        logic [5:0] noload_change;
    } emoc_irq_stat_t;

endpackage

// >>> rtl/emoc_capture.sv
// one overcurrent capture channel: compare and hold rms value
// assumes rms input is synchronous to clock_i and valid every cycle
`timescale 1ns/100ps
`default_nettype none

module emoc_capture
    import emoc_pkg::*;
#(
    parameter int VAL_W = 24
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    // compare inputs
    input  wire logic             enable_i,
    input  wire logic [VAL_W-1:0] threshold_i,
    input  wire logic [VAL_W-1:0] rms_i,
    // captured value
    output logic      [VAL_W-1:0] capture_o
);

    if (VAL_W < 1 || VAL_W > 24) begin : g_chk
        $error("emoc_capture: VAL_W must be 1 to 24");
    end

    logic hit;

    // update only while enabled and strictly above threshold
    assign hit = enable_i && (rms_i > threshold_i);

    // capture register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            capture_o <= OC_CAP_RST[VAL_W-1:0];
        end else if (hit) begin
            capture_o <= rms_i;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    cap_update_a: assert property (
        hit |=> capture_o == $past(rms_i))
        else $error("capture did not take rms value");
    cap_hold_a: assert property (
        !hit |=> $stable(capture_o))
        else $error("capture changed without overcurrent");

endmodule

`default_nettype wire

// >>> rtl/emoc_top.sv
// event pin mask, interrupt mask low part and overcurrent capture block
// assumes all inputs synchronous to clock_i; register port is the
// internal side of the serial port, one word access per strobe
//
// Function
// - per-phase zero-crossing timeout interrupt enables, bits 8-6
// - six no-load change interrupt enables, bits 5-0
// - bit 16 pulls event pin on sample ready
// - bits 15-10 pull event pin on no-load
// - bits 9-6 negative pulse direction, falling-edge latched
// - bits 5-3 pull event pin during swell
// - bits 2-0 pull event pin during dip
// - 24-bit threshold, resets all ones, upper read-only
// - phase captures take rms above threshold when enabled
// - neutral capture likewise against same threshold
// - fundamental level register, reset 0x45D45, drives output
// - bit 17 enables overcurrent interrupt
`timescale 1ns/100ps
`default_nettype none

module emoc_top
    import emoc_pkg::*;
#(
    parameter int VAL_W = 24,
    parameter int OC_CH = 4
) (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       srst_i,
    // register port
    input  wire emoc_reg_req_t              reg_req_i,
    output logic      [31:0]                rd_data_o,
    output logic                            rd_valid_o,
    // metrology conditions
    input  wire logic                       wave_sample_ready_i,
    input  wire logic [5:0]                 noload_i,
    input  wire logic [3:0]                 energy_pulse_out_i,
    input  wire logic [3:0]                 neg_energy_i,
    input  wire emoc_pq_t                   pq_i,
    input  wire emoc_irq_stat_t             irq_stat_i,
    // overcurrent inputs, channels a, b, c, neutral
    input  wire logic [OC_CH-1:0]           overcurrent_enable_i,
    input  wire logic [OC_CH-1:0][VAL_W-1:0] half_cycle_rms_i,
    // outputs
    output logic                            irq_o,
    output logic                            event_n_o,
    output logic      [VAL_W-1:0]           fundamental_level_o
);

    if (VAL_W != 24 || OC_CH != 4) begin : g_chk
        $error("emoc_top: VAL_W must be 24 and OC_CH 4");
    end

    logic [31:0]                  irq_mask;
    logic [31:0]                  event_mask;
    logic [VAL_W-1:0]             oc_threshold;
    logic [OC_CH-1:0][VAL_W-1:0]  oc_capture;
    logic [3:0]                   pulse_prev;
    logic [3:0]                   neg_dir;
    logic [31:0]                  next_rd_data;
    logic [16:0]                  evt_cond;
    logic [17:0]                  irq_cond;

    // mask register writes, reserved bits dropped
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_mask   <= IRQ_MASK_RST;
            event_mask <= EVT_MASK_RST;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == ADDR_IRQ_MASK) begin
                irq_mask <= reg_req_i.wdata & IRQ_MASK_WR;
            end
            if (reg_req_i.addr == ADDR_EVT_MASK) begin
                event_mask <= reg_req_i.wdata & EVT_MASK_WR;
            end
        end
    end

    // threshold and fundamental level registers
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            oc_threshold        <= OC_THRESH_RST;
            fundamental_level_o <= FUND_LVL_RST;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == ADDR_OC_THRESH) begin
                oc_threshold <= reg_req_i.wdata[VAL_W-1:0];
            end
            if (reg_req_i.addr == ADDR_FUND_LVL) begin
                fundamental_level_o <= reg_req_i.wdata[VAL_W-1:0];
            end
        end
    end

    // capture channels, last one is neutral
    for (genvar ch = 0; ch < OC_CH; ch++) begin : g_cap
        emoc_capture #(
            .VAL_W      (VAL_W)
        ) u_cap (
            .clock_i    (clock_i),
            .srst_i     (srst_i),
            .enable_i   (overcurrent_enable_i[ch]),
            .threshold_i(oc_threshold),
            .rms_i      (half_cycle_rms_i[ch]),
            .capture_o  (oc_capture[ch])
        );
    end

    // pulse direction latched on each falling pulse edge
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pulse_prev <= 4'h0;
            neg_dir    <= 4'h0;
        end else begin
            pulse_prev <= energy_pulse_out_i;
            for (int k = 0; k < 4; k++) begin
                if (pulse_prev[k] && !energy_pulse_out_i[k]) begin
                    neg_dir[k] <= neg_energy_i[k];
                end
            end
        end
    end

    // event pin conditions in mask bit order
    assign evt_cond = {wave_sample_ready_i, noload_i, neg_dir,
                       pq_i.swell, pq_i.dip};

    // interrupt conditions in mask bit order
    assign irq_cond = {irq_stat_i.overcurrent, 8'h00,
                       irq_stat_i.zc_timeout, irq_stat_i.noload_change};

    // active-low event pin and active-high interrupt output
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            event_n_o <= 1'b1;
            irq_o     <= 1'b0;
        end else begin
            event_n_o <= ~|(evt_cond & event_mask[16:0]);
            irq_o     <= |(irq_cond & irq_mask[17:0]);
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        next_rd_data = 32'h00000000;
        case (reg_req_i.addr)
            ADDR_IRQ_MASK:  next_rd_data = irq_mask;
            ADDR_EVT_MASK:  next_rd_data = event_mask;
            ADDR_OC_THRESH: next_rd_data = {8'h00, oc_threshold};
            ADDR_OC_CAP_A:  next_rd_data = {8'h00, oc_capture[0]};
            ADDR_OC_CAP_B:  next_rd_data = {8'h00, oc_capture[1]};
            ADDR_OC_CAP_C:  next_rd_data = {8'h00, oc_capture[2]};
            ADDR_OC_CAP_N:  next_rd_data = {8'h00, oc_capture[3]};
            ADDR_FUND_LVL:  next_rd_data = {8'h00, fundamental_level_o};
            default:        next_rd_data = 32'h00000000;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rd_data_o  <= 32'h00000000;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    irq_zc_to_a: assert property (
        irq_mask[IRQ_ZXTO_LSB] && irq_stat_i.zc_timeout[0] |=> irq_o)
        else $error("zero-crossing timeout interrupt missing");
    irq_noload_a: assert property (
        irq_mask[IRQ_NOLOAD_LSB+5] && irq_stat_i.noload_change[5]
        |=> irq_o)
        else $error("no-load interrupt missing");
    evt_ready_a: assert property (
        event_mask[EVT_WAVE_SAMPLE_READY_EN_BIT] && wave_sample_ready_i |=> !event_n_o)
        else $error("sample ready did not pull event pin");
    evt_noload_a: assert property (
        event_mask[EVT_NOLOAD_LSB] && noload_i[0] |=> !event_n_o)
        else $error("no-load did not pull event pin");
    evt_negdir_a: assert property (
        $fell(energy_pulse_out_i[0]) && neg_energy_i[0]
        ##1 event_mask[EVT_NEGDIR_LSB] |=> !event_n_o)
        else $error("negative pulse did not pull event pin");
    evt_swell_a: assert property (
        event_mask[EVT_SWELL_LSB+2] && pq_i.swell[2] |=> !event_n_o)
        else $error("swell did not pull event pin");
    evt_dip_a: assert property (
        event_mask[EVT_DIP_LSB+1] && pq_i.dip[1] |=> !event_n_o)
        else $error("dip did not pull event pin");
    thresh_rsv_a: assert property (
        reg_req_i.rd && reg_req_i.addr == ADDR_OC_THRESH
        |=> rd_valid_o && rd_data_o[31:24] == 8'h00)
        else $error("threshold reserved bits not zero");
    neutral_cap_a: assert property (
        overcurrent_enable_i[OC_CH_N]
        && half_cycle_rms_i[OC_CH_N] > oc_threshold
        |=> oc_capture[OC_CH_N] == $past(half_cycle_rms_i[OC_CH_N]))
        else $error("neutral capture not updated");
    level_wr_a: assert property (
        reg_req_i.wr && reg_req_i.addr == ADDR_FUND_LVL
        |=> fundamental_level_o == $past(reg_req_i.wdata[23:0]))
        else $error("level register not written");
    irq_oc_a: assert property (
        irq_mask[IRQ_OI_BIT] && irq_stat_i.overcurrent |=> irq_o)
        else $error("overcurrent interrupt missing");
    irq_gate_a: assert property (
        !(|(irq_cond & irq_mask[17:0])) |=> !irq_o)
        else $error("interrupt without enabled status");
    mask_rsv_a: assert property (
        event_mask[31:17] == 15'h0000 && irq_mask[16:9] == 8'h00)
        else $error("reserved mask bits set");

    cov_evt_low: cover property (event_n_o ##1 !event_n_o);
    cov_irq: cover property (!irq_o ##1 irq_o);
    cov_cap_a: cover property (
        overcurrent_enable_i[OC_CH_A]
        && half_cycle_rms_i[OC_CH_A] > oc_threshold);

endmodule

`default_nettype wire

// >>> verif/emoc_host_model.sv
// host side of the register port: word reads and writes
// assumes tasks are called from the bench at a falling clock edge
`timescale 1ns/100ps
`default_nettype none

module emoc_host_model
    import emoc_pkg::*;
(
    // clock
    input  wire logic          clock_i,
    // register port
    output var  emoc_reg_req_t reg_req_o,
    input  wire logic [31:0]   rd_data_i,
    input  wire logic          rd_valid_i,
    // event pin as seen by the host
    input  wire logic          event_n_i
);
    // idle port at time zero
    initial begin
        reg_req_o = '0;
    end

    // one write strobe; released lines show the inverted value
    task automatic write(input logic [15:0] a, input logic [31:0] d);
        @(negedge clock_i);
        reg_req_o.wr = 1'b1;
        reg_req_o.addr = a;
        reg_req_o.wdata = d;
        @(negedge clock_i);
        reg_req_o.wr = 1'b0;
        reg_req_o.addr = ~a;
        reg_req_o.wdata = ~d;
    endtask

    // one read strobe; data taken while the valid pulse stands
    task automatic read(input logic [15:0] a, output logic [31:0] d);
        @(negedge clock_i);
        reg_req_o.rd = 1'b1;
        reg_req_o.addr = a;
        @(negedge clock_i);
        reg_req_o.rd = 1'b0;
        reg_req_o.addr = ~a;
        d = (rd_valid_i === 1'b1) ? rd_data_i : 32'hBADBAD00;
    endtask
endmodule

`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the event mask and overcurrent capture block
// assumes the host model drives the register port of emoc_top
`timescale 1ns/100ps
`default_nettype none

module tb
    import emoc_pkg::*;
;

    // stimulus and observed outputs
    logic             clock_i;
    logic             srst_i;
    emoc_reg_req_t    reg_req;
    logic [31:0]      rd_data;
    logic             rd_valid;
    logic             ready;
    logic [5:0]       noload;
    logic [3:0]       pulse;
    logic [3:0]       neg;
    emoc_pq_t         pq;
    emoc_irq_stat_t   stat;
    logic [3:0]       oc_en;
    logic [3:0][23:0] rms;
    logic             irq;
    logic             event_n;
    logic [23:0]      level;
    logic [31:0]      rd;
    int               failures;
    int               n_checks;
    int               cycles;

    // register table: address, reset value, value after all-ones write
    localparam logic [15:0] ADDRS [9] = '{ADDR_IRQ_MASK, ADDR_EVT_MASK,
        ADDR_OC_THRESH, ADDR_OC_CAP_A, ADDR_OC_CAP_B, ADDR_OC_CAP_C,
        ADDR_OC_CAP_N, ADDR_FUND_LVL, 16'h0408};
    localparam logic [31:0] RSTV [9] = '{32'h0, 32'h0, 32'h00FFFFFF,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h00045D45, 32'h0};
    localparam logic [31:0] ONES [9] = '{32'h000201FF, 32'h0001FFFF,
        32'h00FFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00FFFFFF, 32'h0};

    emoc_top emoc_top_inst (
        .clock_i(clock_i), .srst_i(srst_i), .reg_req_i(reg_req),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .wave_sample_ready_i(ready), .noload_i(noload),
        .energy_pulse_out_i(pulse), .neg_energy_i(neg), .pq_i(pq),
        .irq_stat_i(stat), .overcurrent_enable_i(oc_en),
        .half_cycle_rms_i(rms), .irq_o(irq), .event_n_o(event_n),
        .fundamental_level_o(level));

    emoc_host_model emoc_host_model_inst (
        .clock_i(clock_i), .reg_req_o(reg_req), .rd_data_i(rd_data),
        .rd_valid_i(rd_valid), .event_n_i(event_n));

    // 250 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // cycle ceiling against a hung run
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        emoc_host_model_inst.read(a, rd);
        check($sformatf("reg %h", a), rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // drive the condition behind one event mask bit
    task automatic set_cond(input int b, input logic v);
        if (b < 3) pq.dip[b] = v;
        else if (b < 6) pq.swell[b-3] = v;
        else if (b == 16) ready = v;
        else noload[b-10] = v;
    endtask

    task automatic results();
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial begin
        srst_i = 1'b1;
        ready = 1'b0;
        noload = '0;
        pulse = '0;
        neg = '0;
        pq = '0;
        stat = '0;
        oc_en = '0;
        rms = '0;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        srst_i = 1'b0;
        check("reset pin", {31'h0, event_n}, 32'h1);
        check("reset irq", {31'h0, irq}, 32'h0);
        // reset values, then all-ones writes incl. read-only and unmapped
        check("level", {8'h00, level}, 32'h00045D45);
        for (int i = 0; i < 9; i++) rd_chk(ADDRS[i], RSTV[i]);
        for (int i = 0; i < 9; i++)
            emoc_host_model_inst.write(ADDRS[i], 32'hFFFFFFFF);
        for (int i = 0; i < 9; i++) rd_chk(ADDRS[i], ONES[i]);
        check("level", {8'h00, level}, 32'h00FFFFFF);
        emoc_host_model_inst.write(ADDR_IRQ_MASK, 32'h0);
        emoc_host_model_inst.write(ADDR_EVT_MASK, 32'h0);
        // level-type event conditions, masked and enabled
        for (int b = 0; b <= 16; b++) begin
            if (b >= 6 && b <= 9) continue;
            set_cond(b, 1'b1);
            cyc(2);
            check("masked pin", {31'h0, event_n}, 32'h1);
            emoc_host_model_inst.write(ADDR_EVT_MASK, 32'h1 << b);
            cyc(2);
            check("event pin", {31'h0, event_n}, 32'h0);
            set_cond(b, 1'b0);
            cyc(2);
            check("idle pin", {31'h0, event_n}, 32'h1);
            emoc_host_model_inst.write(ADDR_EVT_MASK, 32'h0);
        end
        // pulse direction latched only at the falling edge
        for (int k = 0; k < 4; k++) begin
            emoc_host_model_inst.write(ADDR_EVT_MASK, 32'h40 << k);
            neg[k] = 1'b1;
            pulse[k] = 1'b1;
            cyc(2);
            check("pre-fall pin", {31'h0, event_n}, 32'h1);
            pulse[k] = 1'b0;
            cyc(3);
            check("negative pin", {31'h0, event_n}, 32'h0);
            neg[k] = 1'b0;
            pulse[k] = 1'b1;
            cyc(1);
            pulse[k] = 1'b0;
            cyc(3);
            check("positive pin", {31'h0, event_n}, 32'h1);
            emoc_host_model_inst.write(ADDR_EVT_MASK, 32'h0);
        end
        // each interrupt status against its mask bit
        for (int i = 0; i < 10; i++) begin
            stat = emoc_irq_stat_t'(10'h001 << i);
            cyc(2);
            check("masked irq", {31'h0, irq}, 32'h0);
            emoc_host_model_inst.write(ADDR_IRQ_MASK,
                (i == 9) ? 32'h00020000 : 32'h1 << i);
            cyc(1);
            check("irq", {31'h0, irq}, 32'h1);
            emoc_host_model_inst.write(ADDR_IRQ_MASK, 32'h0);
            cyc(1);
            check("cleared irq", {31'h0, irq}, 32'h0);
            stat = '0;
        end
        // capture: equal value, disabled channel, capture and hold
        emoc_host_model_inst.write(ADDR_OC_THRESH, 32'h00000100);
        for (int c = 0; c < 4; c++) begin
            rms[c] = 24'h000100;
            oc_en[c] = 1'b1;
            cyc(2);
            rd_chk(ADDR_OC_CAP_A + 16'(c), 32'h0);
            oc_en[c] = 1'b0;
            rms[c] = 24'h000101;
            cyc(2);
            rd_chk(ADDR_OC_CAP_A + 16'(c), 32'h0);
            oc_en[c] = 1'b1;
            cyc(2);
            rd_chk(ADDR_OC_CAP_A + 16'(c), 32'h00000101);
            rms[c] = 24'h000050;
            cyc(2);
            rd_chk(ADDR_OC_CAP_A + 16'(c), 32'h00000101);
            oc_en[c] = 1'b0;
        end
        // mid-run reset with the pin pulled and captures loaded
        emoc_host_model_inst.write(ADDR_EVT_MASK, 32'h00010000);
        ready = 1'b1;
        cyc(2);
        check("event pin", {31'h0, event_n}, 32'h0);
        srst_i = 1'b1;
        cyc(2);
        srst_i = 1'b0;
        check("reset pin", {31'h0, event_n}, 32'h1);
        check("level", {8'h00, level}, 32'h00045D45);
        for (int i = 0; i < 9; i++) rd_chk(ADDRS[i], RSTV[i]);
        check("cleared mask pin", {31'h0, event_n}, 32'h1);
        ready = 1'b0;
        results();
    end
endmodule

`default_nettype wire
